// >>> overlay_pkg.sv
// constants and types shared by the serial overlay command parser
package overlay_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int DIV_W = 18;
  // bit rates selected by the straps
  localparam int unsigned BAUD_1200 = 1200;
  localparam int unsigned BAUD_2400 = 2400;
  localparam int unsigned BAUD_4800 = 4800;
  localparam int unsigned BAUD_9600 = 9600;
  localparam int unsigned BAUD_19200 = 19200;
  localparam int unsigned BAUD_38400 = 38400;
  localparam int unsigned BAUD_76800 = 76800;
  localparam int unsigned BAUD_153600 = 153600;
  localparam int unsigned BAUD_115200 = 115200;
  // strap codes when the standard-rate strap is grounded
  localparam logic [2:0] S_1200 = 3'h0;
  localparam logic [2:0] S_2400 = 3'h1;
  localparam logic [2:0] S_4800 = 3'h5;
  localparam logic [2:0] S_19200 = 3'h3;
  localparam logic [2:0] S_38400 = 3'h6;
  localparam logic [2:0] S_76800 = 3'h2;
  localparam logic [2:0] S_153600 = 3'h4;
  // strap codes when it is open
  localparam logic [2:0] S_HW_FLOW = 3'h3;
  localparam logic [2:0] S_SW_FLOW = 3'h7;
  // bytes of the stream
  localparam logic [7:0] C_STX = 8'h02;
  localparam logic [7:0] C_ETX = 8'h03;
  localparam logic [7:0] C_BS = 8'h08;
  localparam logic [7:0] C_LF = 8'h0A;
  localparam logic [7:0] C_FF = 8'h0C;
  localparam logic [7:0] C_CR = 8'h0D;
  localparam logic [7:0] C_XON = 8'h11;
  localparam logic [7:0] C_XOFF = 8'h13;
  localparam logic [7:0] C_CAN = 8'h18;
  localparam logic [7:0] C_ESC = 8'h1B;
  localparam logic [7:0] C_SPACE = 8'h20;
  localparam logic [7:0] C_DEL = 8'h7F;
  localparam logic [7:0] C_LBRK = 8'h5B;
  localparam logic [7:0] C_SEMI = 8'h3B;
  localparam logic [7:0] C_MINUS = 8'h3C;
  localparam logic [7:0] C_DOT = 8'h2E;
  localparam logic [7:0] C_ZERO = 8'h30;
  localparam logic [7:0] C_NINE = 8'h39;
  localparam logic [7:0] C_FIN_LO = 8'h40;
  localparam logic [7:0] C_FIN_HI = 8'h7E;
  // receive buffer and flow thresholds
  localparam int RX_FIFO_W = 8;
  localparam int RX_FIFO_D = 16;
  localparam logic [4:0] FIFO_FULL = 5'h10;
  localparam logic [4:0] FIFO_HI = 5'h0C;
  localparam logic [4:0] FIFO_LO = 5'h04;
  // screen and operands
  localparam logic [4:0] SCR_LAST_ROW = 5'h0F;
  localparam logic [5:0] SCR_LAST_COL = 6'h27;
  localparam int STR_MAX = 1024;
  localparam logic [10:0] STR_MAX_LEN = 11'h400;
  localparam int NARGS = 4;
  // online announcement after start-up, below one second
  localparam int unsigned STARTUP_MS = 500;
  localparam int unsigned STARTUP_CYC = CLK_HZ / 1000 * STARTUP_MS;

  typedef enum logic [2:0] {P_TEXT, P_ESC, P_CSI, P_STR} pstate_type;

  function automatic logic [DIV_W-1:0] div_for(input logic std_n, input logic [2:0] s);
    logic [DIV_W-1:0] d;
    d = DIV_W'(CLK_HZ / BAUD_9600);
    if (!std_n) begin
      case (s)
        S_1200: d = DIV_W'(CLK_HZ / BAUD_1200);
        S_2400: d = DIV_W'(CLK_HZ / BAUD_2400);
        S_4800: d = DIV_W'(CLK_HZ / BAUD_4800);
        S_19200: d = DIV_W'(CLK_HZ / BAUD_19200);
        S_38400: d = DIV_W'(CLK_HZ / BAUD_38400);
        S_76800: d = DIV_W'(CLK_HZ / BAUD_76800);
        S_153600: d = DIV_W'(CLK_HZ / BAUD_153600);
        default: d = DIV_W'(CLK_HZ / BAUD_9600);
      endcase
    end else if (s == S_HW_FLOW || s == S_SW_FLOW) begin
      d = DIV_W'(CLK_HZ / BAUD_115200);
    end
    return d;
  endfunction : div_for
endpackage : overlay_pkg

// >>> overlay_parser.sv
// serial receive buffer and overlay command parser
// Function
// [RULE1] frames are 8 data, no parity, 1 stop
// [RULE2] 9600 default, straps sampled once after reset
// [RULE3] software mode sends pause/resume by fill level
// [RULE4] hardware stop only when buffer full
// [RULE5] host starts nothing after stop indication
// [RULE6] transmitter halts between characters while paused
// [RULE7] resume byte sent below one second after start
// [RULE8] carriage return and line feed act separately
// [RULE9] backspace moves back, ignored at line start
// [RULE10] advancing past screen end scrolls upward
// [RULE11] form feed clears screen, cursor home
// [RULE12] escape then bracket opens a command
// [RULE13] final byte identifies command, case-sensitive
// [RULE14] decimal arguments, semicolons, omissions allowed
// [RULE15] malformed sequences are dropped silently
// [RULE16] start/end bytes bound a 1024-byte string
// [RULE17] cancel byte aborts string capture
// [RULE18] captured string bytes are never printed
// [RULE19] less-than sign negates an argument
// [RULE20] two-byte characters up to 0x7FF
// [RULE21] three-byte characters up to 0xFFFF
// [RULE22] high-bit bytes are never controls
// [RULE23] characters drawn at cursor, cursor advances
`timescale 1ns/100ps
`default_nettype none

module byte_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i,
  output logic [$clog2(D):0] level_o
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_type;
  fifo_type s_reg, s_next;
  logic [W-1:0] mem [D];
  logic push, pop;

  assign in_ready_o = s_reg.cnt != (AW+1)'(D);
  assign out_valid_o = s_reg.cnt != '0;
  assign out_data_o = mem[s_reg.rp];
  assign level_o = s_reg.cnt;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    s_next = s_reg;
    if (push) s_next.wp = s_reg.wp + 1'b1;
    if (pop) s_next.rp = s_reg.rp + 1'b1;
    if (push && !pop) s_next.cnt = s_reg.cnt + 1'b1;
    else if (pop && !push) s_next.cnt = s_reg.cnt - 1'b1;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) s_reg <= '0;
    else s_reg <= s_next;
  end

  always_ff @(posedge clk_i) begin
    if (push) mem[s_reg.wp] <= in_data_i;
  end
endmodule : byte_fifo

module overlay_parser
  import overlay_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = STARTUP_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  // straps
  input wire logic strap_std_n_i,
  input wire logic [2:0] strap_rate_i,
  // serial link
  input wire logic rxd_i,
  output logic txd_o,
  output logic rts_stop_o,
  input wire logic cts_stop_i,
  // display side
  input wire logic busy_i,
  output logic draw_o,
  output logic [15:0] char_o,
  output logic [4:0] row_o,
  output logic [5:0] col_o,
  output logic clear_o,
  output logic scroll_o,
  // commands
  output logic cmd_o,
  output logic [7:0] cmd_id_o,
  output logic [NARGS-1:0] cmd_present_o,
  output logic cmd_dot_o,
  output logic [NARGS-1:0][15:0] cmd_args_o,
  // string operand
  output logic str_done_o,
  output logic [10:0] str_len_o,
  input wire logic [9:0] str_addr_i,
  output logic [7:0] str_data_o
);
  typedef struct packed {
    logic cfg_done;
    logic hw_flow;
    logic [DIV_W-1:0] div;
    logic rx_busy;
    logic [DIV_W-1:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic [7:0] hold;
    logic hold_v;
    logic tx_busy;
    logic [DIV_W-1:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [8:0] tx_sh;
    logic txd;
    logic xoff_on;
    logic online;
    logic [26:0] boot_cnt;
    logic rts;
    pstate_type ps;
    logic [1:0] ucnt;
    logic [15:0] ucode;
    logic [NARGS-1:0][15:0] args;
    logic [NARGS-1:0] present;
    logic [2:0] argi;
    logic [15:0] acc;
    logic dig;
    logic neg;
    logic dot;
    logic bad;
    logic [4:0] row;
    logic [5:0] col;
    logic draw;
    logic [15:0] chr;
    logic [4:0] drow;
    logic [5:0] dcol;
    logic clr;
    logic scroll;
    logic cmd;
    logic [7:0] cmd_id;
    logic [NARGS-1:0] cmd_present;
    logic cmd_dot;
    logic [NARGS-1:0][15:0] cmd_args;
    logic [10:0] str_len;
    logic [10:0] str_wr;
    logic str_done;
    logic str_we;
    logic [7:0] str_wd;
  } state_type;

  state_type s_reg, s_next;
  logic [7:0] str_mem [STR_MAX];
  logic [7:0] str_data_reg;
  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [7:0] fifo_out;
  logic [4:0] level;

  // display back-pressure stalls the drain so the buffer can really fill
  assign fifo_pop = fifo_out_valid && !busy_i;

  byte_fifo #(.W(RX_FIFO_W), .D(RX_FIFO_D)) rx_fifo (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .in_valid_i(s_reg.hold_v),
    .in_data_i(s_reg.hold),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out),
    .out_ready_i(fifo_pop),
    .level_o(level)
  );

  function automatic state_type newline(state_type t);
    state_type r;
    r = t;
    if (t.row == SCR_LAST_ROW) r.scroll = 1'b1; // RULE10
    else r.row = t.row + 1'b1;
    return r;
  endfunction : newline

  function automatic state_type print(state_type t, logic [15:0] code);
    state_type r;
    r = t;
    r.draw = 1'b1; // RULE23
    r.chr = code;
    r.drow = t.row;
    r.dcol = t.col;
    if (t.col == SCR_LAST_COL) begin
      r.col = '0;
      r = newline(r); // RULE10
    end else begin
      r.col = t.col + 1'b1; // RULE23
    end
    return r;
  endfunction : print

  function automatic state_type commit(state_type t);
    state_type r;
    r = t;
    if (t.argi < 3'(NARGS)) begin
      r.args[t.argi[1:0]] = t.neg ? 16'(-t.acc) : t.acc; // RULE19
      r.present[t.argi[1:0]] = t.dig; // RULE14
    end else begin
      r.bad = 1'b1; // RULE15
    end
    r.acc = '0;
    r.dig = 1'b0;
    r.neg = 1'b0;
    return r;
  endfunction : commit

  always_comb begin
    logic [7:0] b;
    logic boot_due;
    s_next = s_reg;
    b = fifo_out;
    boot_due = s_reg.boot_cnt == 27'(STARTUP_CYCLES - 1);
    s_next.draw = 1'b0;
    s_next.clr = 1'b0;
    s_next.scroll = 1'b0;
    s_next.cmd = 1'b0;
    s_next.str_done = 1'b0;
    s_next.str_we = 1'b0;
    // straps are caught once, on the first edge after release
    if (!s_reg.cfg_done) begin
      s_next.cfg_done = 1'b1; // RULE2
      s_next.div = div_for(strap_std_n_i, strap_rate_i); // RULE2
      s_next.hw_flow = strap_std_n_i && strap_rate_i == S_HW_FLOW;
    end
    // receiver, sampled mid-bit
    if (s_reg.hold_v && fifo_in_ready) s_next.hold_v = 1'b0;
    if (!s_reg.rx_busy) begin
      if (s_reg.cfg_done && !rxd_i) begin
        s_next.rx_busy = 1'b1;
        s_next.rx_cnt = s_reg.div >> 1;
        s_next.rx_bit = '0;
      end
    end else if (s_reg.rx_cnt != '0) begin
      s_next.rx_cnt = s_reg.rx_cnt - 1'b1;
    end else begin
      s_next.rx_cnt = s_reg.div - 1'b1;
      if (s_reg.rx_bit == 4'h0) begin
        if (rxd_i) s_next.rx_busy = 1'b0;
        else s_next.rx_bit = 4'h1;
      end else if (s_reg.rx_bit <= 4'h8) begin
        s_next.rx_sh = {rxd_i, s_reg.rx_sh[7:1]}; // RULE1
        s_next.rx_bit = s_reg.rx_bit + 1'b1;
      end else begin
        s_next.rx_busy = 1'b0;
        // a frame arriving while the holding byte is still stuck is lost
        if (rxd_i && (!s_reg.hold_v || fifo_in_ready)) begin // RULE1 RULE5
          s_next.hold = s_reg.rx_sh;
          s_next.hold_v = 1'b1;
        end
      end
    end
    s_next.rts = s_reg.hw_flow && level == FIFO_FULL; // RULE4
    // transmitter
    if (!s_reg.online && !boot_due) s_next.boot_cnt = s_reg.boot_cnt + 1'b1;
    if (s_reg.tx_busy) begin
      if (s_reg.tx_cnt != '0) begin
        s_next.tx_cnt = s_reg.tx_cnt - 1'b1;
      end else if (s_reg.tx_bit == 4'h0) begin
        s_next.tx_busy = 1'b0;
      end else begin
        s_next.tx_cnt = s_reg.div - 1'b1;
        s_next.txd = s_reg.tx_sh[0];
        s_next.tx_sh = {1'b1, s_reg.tx_sh[8:1]};
        s_next.tx_bit = s_reg.tx_bit - 1'b1;
      end
    end else if (s_reg.cfg_done && !(s_reg.hw_flow && cts_stop_i)) begin // RULE6
      if (!s_reg.online && boot_due) begin
        s_next.online = 1'b1; // RULE7
        s_next.tx_sh = {1'b1, C_XON};
        s_next.tx_busy = 1'b1;
      end else if (s_reg.online && !s_reg.hw_flow && !s_reg.xoff_on && level >= FIFO_HI) begin
        s_next.xoff_on = 1'b1; // RULE3
        s_next.tx_sh = {1'b1, C_XOFF};
        s_next.tx_busy = 1'b1;
      end else if (s_reg.online && !s_reg.hw_flow && s_reg.xoff_on && level <= FIFO_LO) begin
        s_next.xoff_on = 1'b0; // RULE3
        s_next.tx_sh = {1'b1, C_XON};
        s_next.tx_busy = 1'b1;
      end
      if (s_next.tx_busy) begin
        s_next.txd = 1'b0; // RULE1
        s_next.tx_cnt = s_reg.div - 1'b1;
        s_next.tx_bit = 4'h9;
      end
    end
    // parser
    if (fifo_pop) begin
      case (s_reg.ps)
        P_STR: begin
          if (b == C_CAN) begin
            s_next.ps = P_TEXT; // RULE17
            s_next.str_len = '0;
          end else if (b == C_ETX) begin
            s_next.ps = P_TEXT; // RULE16
            s_next.str_len = s_reg.str_wr;
            s_next.str_done = 1'b1;
          end else if (s_reg.str_wr != STR_MAX_LEN) begin
            s_next.str_we = 1'b1; // RULE16 RULE18
            s_next.str_wd = b;
            s_next.str_wr = s_reg.str_wr + 1'b1;
          end
        end
        P_ESC: begin
          s_next.ps = P_TEXT; // RULE15
          if (b == C_LBRK) begin
            s_next.ps = P_CSI; // RULE12
            s_next.args = '0;
            s_next.present = '0;
            s_next.argi = '0;
            s_next.acc = '0;
            s_next.dig = 1'b0;
            s_next.neg = 1'b0;
            s_next.dot = 1'b0;
            s_next.bad = 1'b0;
          end
        end
        P_CSI: begin
          if (b >= C_ZERO && b <= C_NINE) begin
            if (s_reg.dot) s_next.bad = 1'b1;
            s_next.acc = 16'(s_reg.acc * 16'h000A + 16'(b - C_ZERO)); // RULE14
            s_next.dig = 1'b1;
          end else if (b == C_MINUS) begin
            if (s_reg.dig || s_reg.neg) s_next.bad = 1'b1; // RULE15
            s_next.neg = 1'b1; // RULE19
          end else if (b == C_SEMI) begin
            s_next = commit(s_next); // RULE14
            s_next.argi = s_reg.argi + 1'b1;
          end else if (b == C_DOT) begin
            s_next.dot = 1'b1;
          end else if (b >= C_FIN_LO && b <= C_FIN_HI) begin
            s_next = commit(s_next);
            s_next.ps = P_TEXT;
            if (!s_next.bad) begin // RULE15
              s_next.cmd = 1'b1;
              s_next.cmd_id = b; // RULE13
              s_next.cmd_present = s_next.present;
              s_next.cmd_args = s_next.args;
              s_next.cmd_dot = s_reg.dot;
            end
          end else begin
            s_next.ps = P_TEXT; // RULE15
          end
          s_next.draw = 1'b0;
          s_next.clr = 1'b0;
          s_next.scroll = 1'b0;
          s_next.str_done = 1'b0;
          s_next.str_we = 1'b0;
        end
        default: begin
          if (s_reg.ucnt != '0) begin
            s_next.ucnt = '0;
            if (b[7:6] == 2'b10) begin
              s_next.ucode = {s_reg.ucode[9:0], b[5:0]}; // RULE20 RULE21
              s_next.ucnt = s_reg.ucnt - 1'b1;
              if (s_reg.ucnt == 2'h1) s_next = print(s_next, s_next.ucode);
            end
          end else if (b[7:5] == 3'b110) begin
            s_next.ucnt = 2'h1; // RULE20
            s_next.ucode = {11'h000, b[4:0]};
          end else if (b[7:4] == 4'b1110) begin
            s_next.ucnt = 2'h2; // RULE21
            s_next.ucode = {12'h000, b[3:0]};
          end else if (b[7]) begin
            s_next.ucnt = '0; // RULE22
          end else if (b == C_ESC) begin
            s_next.ps = P_ESC; // RULE12
          end else if (b == C_STX) begin
            s_next.ps = P_STR; // RULE16
            s_next.str_wr = '0;
          end else if (b == C_CR) begin
            s_next.col = '0; // RULE8
          end else if (b == C_LF) begin
            s_next = newline(s_next); // RULE8
          end else if (b == C_BS) begin
            if (s_reg.col != '0) s_next.col = s_reg.col - 1'b1; // RULE9
          end else if (b == C_FF) begin
            s_next.clr = 1'b1; // RULE11
            s_next.row = '0;
            s_next.col = '0;
          end else if (b >= C_SPACE && b != C_DEL) begin
            s_next = print(s_next, {8'h00, b}); // RULE23
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_reg <= '0;
      s_reg.txd <= 1'b1;
      s_reg.ps <= P_TEXT;
    end else begin
      s_reg <= s_next;
    end
  end

  // string storage has no reset; its read port does
  always_ff @(posedge clk_i) begin
    if (s_reg.str_we) str_mem[s_reg.str_wr[9:0] - 10'h001] <= s_reg.str_wd;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) str_data_reg <= '0;
    else str_data_reg <= str_mem[str_addr_i];
  end

  assign txd_o = s_reg.txd;
  assign rts_stop_o = s_reg.rts;
  assign draw_o = s_reg.draw;
  assign char_o = s_reg.chr;
  assign row_o = s_reg.drow;
  assign col_o = s_reg.dcol;
  assign clear_o = s_reg.clr;
  assign scroll_o = s_reg.scroll;
  assign cmd_o = s_reg.cmd;
  assign cmd_id_o = s_reg.cmd_id;
  assign cmd_present_o = s_reg.cmd_present;
  assign cmd_dot_o = s_reg.cmd_dot;
  assign cmd_args_o = s_reg.cmd_args;
  assign str_done_o = s_reg.str_done;
  assign str_len_o = s_reg.str_len;
  assign str_data_o = str_data_reg;
endmodule : overlay_parser

`default_nettype wire

// >>> overlay_parser_assertions.sv
// port checker for the overlay parser, bound into it
`timescale 1ns/100ps
`default_nettype none
module overlay_parser_assertions
  import overlay_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = 50
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // link and standard-rate strap
  input wire logic strap_std_n_i,
  input wire logic txd_o,
  input wire logic rts_stop_o,
  // display, commands and string operand
  input wire logic draw_o,
  input wire logic [15:0] char_o,
  input wire logic [4:0] row_o,
  input wire logic [5:0] col_o,
  input wire logic clear_o,
  input wire logic cmd_o,
  input wire logic [7:0] cmd_id_o,
  input wire logic [NARGS-1:0] cmd_present_o,
  input wire logic [NARGS-1:0][15:0] cmd_args_o,
  input wire logic str_done_o,
  input wire logic [10:0] str_len_o
);
  typedef struct packed {
    logic [31:0] cnt;
  } chk_state_type;
  chk_state_type state_reg;
  chk_state_type state_next;
  logic omit_ok;

  // saturates so a long run never wraps back into the start-up window
  always_comb begin
    state_next = state_reg;
    if (state_reg.cnt < STARTUP_CYCLES + 16) begin
      state_next.cnt = state_reg.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    omit_ok = 1'b1;
    for (int i = 0; i < NARGS; i++) begin
      if (!cmd_present_o[i] && cmd_args_o[i] != 16'h0) begin
        omit_ok = 1'b0;
      end
    end
  end

  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  a_quiet_before_online: assert property (
    state_reg.cnt < STARTUP_CYCLES - 2 |-> txd_o) else $error("txd busy before start-up");
  a_online_start_bit: assert property (
    state_reg.cnt == STARTUP_CYCLES + 4 |-> !txd_o [*4]) else $error("no online byte");
  a_no_draw_beside: assert property (
    draw_o |-> !clear_o && !cmd_o && !str_done_o) else $error("draw beside another action");
  a_pos_on_screen: assert property (
    draw_o |-> row_o <= SCR_LAST_ROW && col_o <= SCR_LAST_COL) else $error("draw off screen");
  a_draw_printable: assert property (
    draw_o |-> char_o >= 16'h0020 && char_o != 16'h007F) else $error("control code drawn");
  a_no_hw_stop: assert property (
    !strap_std_n_i |-> !rts_stop_o) else $error("stop line raised in software mode");
  a_string_len_max: assert property (
    str_done_o |-> str_len_o <= STR_MAX_LEN) else $error("string too long");
  a_final_byte: assert property (
    cmd_o |-> cmd_id_o >= C_FIN_LO && cmd_id_o <= C_FIN_HI) else $error("bad final byte");
  a_omitted_zero: assert property (
    cmd_o |-> omit_ok) else $error("omitted argument not zero");

  c_draw: cover property (draw_o);
  c_cmd_arg: cover property (cmd_o && cmd_present_o[0]);
  c_string: cover property (str_done_o);
  c_clear: cover property (clear_o);
endmodule : overlay_parser_assertions

bind overlay_parser overlay_parser_assertions #(.STARTUP_CYCLES(STARTUP_CYCLES)) chk_u (
  .clk_i(clk_i), .nrst_i(nrst_i), .strap_std_n_i(strap_std_n_i), .txd_o(txd_o),
  .rts_stop_o(rts_stop_o), .draw_o(draw_o), .char_o(char_o), .row_o(row_o), .col_o(col_o),
  .clear_o(clear_o), .cmd_o(cmd_o), .cmd_id_o(cmd_id_o), .cmd_present_o(cmd_present_o),
  .cmd_args_o(cmd_args_o), .str_done_o(str_done_o), .str_len_o(str_len_o)
);
`default_nettype wire

// >>> host_uart_model.sv
// host side serial model: sends frames, decodes what the device sends back
`timescale 1ns/100ps
`default_nettype none
module host_uart_model #(
  parameter int DIV = 1302
) (
  // clock
  input wire logic clk_i,
  // serial link
  input wire logic txd_i,
  input wire logic rts_stop_i,
  output var logic rxd_o
);
  logic [7:0] rx_q[$];
  logic [7:0] rx_b;

  initial begin
    rxd_o = 1'b1;
  end

  // lsb first; holds a frame for up to 200000 cycles while the device asks to stop
  task automatic send_byte(input logic [7:0] b);
    int w;
    w = 0;
    while (rts_stop_i === 1'b1 && w < 200000) begin
      @(posedge clk_i);
      w++;
    end
    @(negedge clk_i);
    rxd_o = 1'b0;
    repeat (DIV) @(negedge clk_i);
    for (int k = 0; k < 8; k++) begin
      rxd_o = b[k];
      repeat (DIV) @(negedge clk_i);
    end
    rxd_o = 1'b1;
    repeat (DIV) @(negedge clk_i);
  endtask : send_byte

  // a frame with a low stop bit is dropped, as a real receiver would
  always begin
    @(negedge txd_i);
    repeat (DIV / 2) @(posedge clk_i);
    if (txd_i === 1'b0) begin
      for (int k = 0; k < 8; k++) begin
        repeat (DIV) @(posedge clk_i);
        rx_b[k] = txd_i;
      end
      repeat (DIV) @(posedge clk_i);
      if (txd_i === 1'b1) begin
        rx_q.push_back(rx_b);
      end
    end
  end
endmodule : host_uart_model
`default_nettype wire

// >>> overlay_parser_tb_top.sv
// self-checking bench of the overlay parser at 153600 bit/s
`timescale 1ns/100ps
`default_nettype none
module overlay_parser_tb_top import overlay_pkg::*;;
  localparam int DIV = CLK_HZ / BAUD_153600;
  typedef logic [7:0] byte_q_type[$];
  logic clk_i;
  logic nrst_i;
  logic strap_std_n_i;
  logic [2:0] strap_rate_i;
  wire rxd_i;
  logic txd_o, rts_stop_o, cts_stop_i, busy_i;
  logic draw_o, clear_o, scroll_o, cmd_o, cmd_dot_o, str_done_o;
  logic [15:0] char_o;
  logic [4:0] row_o;
  logic [5:0] col_o;
  logic [7:0] cmd_id_o, str_data_o;
  logic [NARGS-1:0] cmd_present_o;
  logic [NARGS-1:0][15:0] cmd_args_o;
  logic [10:0] str_len_o;
  logic [9:0] str_addr_i;
  logic [26:0] draw_q[$];
  int n_clear = 0;
  int n_cmd = 0;
  int n_str = 0;
  int n_scroll = 0;
  int fails = 0;
  int n_checks = 0;

  overlay_parser #(.STARTUP_CYCLES(50)) dut_u (
    .clk_i(clk_i), .nrst_i(nrst_i), .strap_std_n_i(strap_std_n_i),
    .strap_rate_i(strap_rate_i), .rxd_i(rxd_i), .txd_o(txd_o), .rts_stop_o(rts_stop_o),
    .cts_stop_i(cts_stop_i), .busy_i(busy_i), .draw_o(draw_o), .char_o(char_o),
    .row_o(row_o), .col_o(col_o), .clear_o(clear_o), .scroll_o(scroll_o), .cmd_o(cmd_o),
    .cmd_id_o(cmd_id_o), .cmd_present_o(cmd_present_o), .cmd_dot_o(cmd_dot_o),
    .cmd_args_o(cmd_args_o), .str_done_o(str_done_o), .str_len_o(str_len_o),
    .str_addr_i(str_addr_i), .str_data_o(str_data_o)
  );

  host_uart_model #(.DIV(DIV)) host_u (
    .clk_i(clk_i), .txd_i(txd_o), .rts_stop_i(rts_stop_o), .rxd_o(rxd_i)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // pulses are caught here since they land in the middle of a stop bit
  always @(posedge clk_i) begin
    if (draw_o === 1'b1) draw_q.push_back({row_o, col_o, char_o});
    if (clear_o === 1'b1) n_clear++;
    if (cmd_o === 1'b1) n_cmd++;
    if (str_done_o === 1'b1) n_str++;
    if (scroll_o === 1'b1) n_scroll++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic expect_draw(input logic [4:0] r, input logic [5:0] c, input logic [15:0] ch);
    logic [26:0] d;
    d = (draw_q.size() > 0) ? draw_q.pop_front() : 'x;
    check(32'(d), {5'h0, r, c, ch}, "draw");
  endtask : expect_draw

  task automatic send_all(input byte_q_type s);
    foreach (s[i]) begin
      host_u.send_byte(s[i]);
    end
    repeat (10) @(posedge clk_i);
  endtask : send_all

  task automatic t_cursor();
    @(negedge clk_i);
    busy_i = 1'b1;
    send_all('{8'h41, C_BS, C_BS, 8'h42, C_LF, 8'h43, C_CR, 8'h44});
    check(32'(draw_q.size()), 32'h0, "draw while stalled");
    @(negedge clk_i);
    busy_i = 1'b0;
    repeat (40) @(posedge clk_i);
    expect_draw(5'h00, 6'h00, 16'h0041);
    expect_draw(5'h00, 6'h00, 16'h0042);
    expect_draw(5'h01, 6'h01, 16'h0043);
    expect_draw(5'h01, 6'h00, 16'h0044);
  endtask : t_cursor

  task automatic t_clear_utf();
    send_all('{C_FF, 8'hC4, 8'hAC, 8'hE1, 8'h8E, 8'h88, 8'h9B});
    check(32'(n_clear), 32'h1, "clears");
    expect_draw(5'h00, 6'h00, 16'h012C);
    expect_draw(5'h00, 6'h01, 16'h1388);
    check(32'(draw_q.size() + n_cmd), 32'h0, "stray high byte acted");
  endtask : t_clear_utf

  task automatic t_command();
    send_all('{C_ESC, C_LBRK, C_MINUS, 8'h35, C_SEMI, 8'h68, C_ESC, 8'h41});
    check(32'(n_cmd), 32'h1, "commands");
    check(32'(cmd_id_o), 32'h68, "command id");
    check(32'(cmd_present_o), 32'h1, "arguments present");
    check(32'(cmd_args_o[0]), 32'hFFFB, "negative argument");
    check(32'(cmd_args_o[1]), 32'h0, "omitted argument");
    check(32'(cmd_dot_o), 32'h0, "dot flag");
    check(32'(draw_q.size()), 32'h0, "broken sequence drew");
  endtask : t_command

  task automatic t_string();
    send_all('{C_STX, 8'h78, C_ETX});
    check(32'(n_str), 32'h1, "string ends");
    check(32'(str_len_o), 32'h1, "string length");
    @(negedge clk_i);
    str_addr_i = 10'h000;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    check(32'(str_data_o), 32'h78, "string byte");
    send_all('{C_STX, 8'h79, C_CAN});
    check(32'(n_str), 32'h1, "aborted string ended");
    check(32'(str_len_o), 32'h0, "length after abort");
    check(32'(draw_q.size()), 32'h0, "string drew");
  endtask : t_string

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // 29 frames of about 13k cycles each, plus margin
  initial begin
    repeat (420000) @(posedge clk_i);
    fails++;
    end_of_test();
  end

  initial begin
    nrst_i = 1'b0;
    strap_std_n_i = 1'b0;
    strap_rate_i = S_153600;
    cts_stop_i = 1'b0;
    busy_i = 1'b0;
    str_addr_i = 10'h3FF;
    repeat (5) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    t_cursor();
    t_clear_utf();
    t_command();
    t_string();
    check(32'(host_u.rx_q.size()), 32'h1, "bytes from device");
    check(32'(host_u.rx_q[0]), 32'(C_XON), "online byte at strap rate");
    check(32'(n_scroll), 32'h0, "scrolls");
    check(32'(rts_stop_o), 32'h0, "stop line in software mode");
    end_of_test();
  end
endmodule : overlay_parser_tb_top
`default_nettype wire
